// >>> hw/udbp_pkg.sv
// udbp_pkg: register map, field positions, timing counts, link types and
// helpers for the ultra dma burst port.
// assumes a 100 MHz system clock and an ahb-lite bus with 32-bit data.
package udbp_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [31:0] ADDR_MODE  = 32'h0000_0000;
  localparam logic [31:0] ADDR_CMD   = 32'h0000_0004;
  localparam logic [31:0] ADDR_STAT  = 32'h0000_0008;
  localparam logic [31:0] ADDR_CRC   = 32'h0000_000C;
  localparam logic [31:0] ADDR_TX    = 32'h0000_0010;
  localparam logic [31:0] ADDR_RX    = 32'h0000_0014;
  localparam logic [31:0] ADDR_IDENT = 32'h0000_0018;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;

  // mode register fields
  localparam int MODE_NUM_LSB  = 0;
  localparam int MODE_SEL_BIT  = 3;
  localparam int MODE_KEEP_BIT = 4;
  // command register fields
  localparam int CMD_START_BIT = 0;
  localparam int CMD_DIR_BIT   = 1;
  localparam int CMD_MEM_BIT   = 2;
  localparam int CMD_SRST_BIT  = 3;
  localparam int CMD_ABRT_BIT  = 4;
  localparam int CMD_CNT_LSB   = 16;
  // status register fields
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_BURST_BIT  = 1;
  localparam int ST_CRCE_BIT   = 2;
  localparam int ST_DONE_BIT   = 3;
  localparam int ST_ABRT_BIT   = 4;
  localparam int ST_RDY_BIT    = 5;
  localparam int ST_TXF_BIT    = 6;
  localparam int ST_MDMA_BIT   = 7;
  localparam int ST_RXC_LSB    = 8;
  localparam int ST_REM_LSB    = 16;
  // receive and identification fields
  localparam int RX_VALID_BIT  = 16;
  localparam int ID_UDMA_BIT   = 0;
  localparam int ID_MASK_LSB   = 8;

  // ****************************************************************
  // capabilities and reset values
  // ****************************************************************
  localparam logic [2:0]  MAX_MODE       = 3'h4;
  localparam logic [4:0]  UDMA_MODE_MASK = 5'h1F;
  localparam logic [2:0]  MODE_RESET     = 3'h0;
  localparam logic [15:0] CRC_SEED       = 16'h4ABA;
  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam int          STORE_DEPTH    = 4;
  localparam int          STORE_AW       = 2;
  localparam logic [STORE_AW:0] STORE_FULL = 3'h4;

  // ****************************************************************
  // timing: strobe half period is half the typical two-word cycle
  // ****************************************************************
  localparam int CLK_NS       = 10;
  localparam int T2CYC_M0_NS  = 240;
  localparam int T2CYC_M1_NS  = 160;
  localparam int T2CYC_M2_NS  = 120;
  localparam int T2CYC_M3_NS  = 90;
  localparam int T2CYC_M4_NS  = 60;
  localparam int HALF_M0 = (T2CYC_M0_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int HALF_M1 = (T2CYC_M1_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int HALF_M2 = (T2CYC_M2_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int HALF_M3 = (T2CYC_M3_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int HALF_M4 = (T2CYC_M4_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] FAST_MODE_MIN = 3'h3;
  localparam logic [2:0] MARGIN_SLOW   = 3'h2;
  localparam logic [2:0] MARGIN_FAST   = 3'h3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_REQ  = 5'b00010,
    S_IN   = 5'b00100,
    S_OUT  = 5'b01000,
    S_TERM = 5'b10000
  } udbp_state_e;

  typedef struct packed {
    logic        dmack_b;
    logic        stop;
    logic        hin;
    logic [15:0] data;
  } udbp_link_in_s;

  localparam udbp_link_in_s LINK_IDLE = '{dmack_b: 1'b1, stop: 1'b0,
                                          hin: 1'b1, data: 16'h0000};

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [3:0] udbp_half(input logic [2:0] m);
    case (m)
      3'h0:    return 4'(HALF_M0);
      3'h1:    return 4'(HALF_M1);
      3'h2:    return 4'(HALF_M2);
      3'h3:    return 4'(HALF_M3);
      default: return 4'(HALF_M4);
    endcase
  endfunction

  function automatic logic [2:0] udbp_margin(input logic [2:0] m);
    return (m >= FAST_MODE_MIN) ? MARGIN_FAST : MARGIN_SLOW;
  endfunction

  // msb-first, one whole word per call
  function automatic logic [15:0] udbp_crc(input logic [15:0] c,
                                           input logic [15:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

endpackage

// >>> hw/udbp_store.sv
// udbp_store: small word store for data-out bursts, registered head word.
// assumes the writer never offers a word when full matters (guarded here).
`timescale 1ns/1ps
`default_nettype none
module udbp_store
  import udbp_pkg::*;
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // write side
  input  wire logic                wr_en,
  input  wire logic [15:0]         wr_data,
  // read side
  input  wire logic                rd_en,
  output logic      [15:0]         rd_data,
  output logic      [STORE_AW:0]   count
);

  logic [15:0]         mem [STORE_DEPTH];
  logic [STORE_AW-1:0] wp;
  logic [STORE_AW-1:0] rp;
  logic [STORE_AW-1:0] next_rp;
  logic                do_wr;
  logic                do_rd;

  assign do_wr   = wr_en && (count != STORE_FULL);
  assign do_rd   = rd_en && (count != '0);
  assign next_rp = do_rd ? rp + 1'b1 : rp;

  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wp] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wp    <= '0;
      rp    <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wp <= wp + 1'b1;
      end
      rp <= next_rp;
      case ({do_wr, do_rd})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end

  // head word is ready on the same edge as any pointer move
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 16'h0000;
    end else if (do_wr && (wp == next_rp)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem[next_rp];
    end
  end

endmodule
`default_nettype wire

// >>> hw/udbp_top.sv
// udbp_top: device end of an ultra dma burst port with an ahb-lite slave.
// assumes link pins are asynchronous to clk_sys and much slower than it.
// Notes on behaviour
// R1: udma moves dma command data when enabled
// R2: udma pin meanings need mode, command, request, ack
// R3: pins revert when host negates dma ack
// R4: pin meanings swap between read and write bursts
// R5: both strobe edges carry one word each
// R6: data driver also makes the strobe
// R7: data placed first, strobe edge after setup
// R8: identification shows udma support and modes
// R9: host selects one mode not above fastest
// R10: every slower mode is accepted too
// R11: soft reset keeps mode unless reverting enabled
// R12: power-on or hardware reset clears udma mode
// R13: host crc compared, mismatch flagged as error
// R14: first crc error of command is reported
// R15: on crc error finish or abort command
// R16: host forwards interrupt on early end
// R17: host holds card selects off, address fixed
// R18: ide mode host holds low address zero
// R19: host writes no task registers mid-command
// R20: every burst word is sixteen bits
// R21: no host memory or io access in bursts
// R22: memory mode host avoids attribute space
// R23: memory mode ready busy for whole command
// R24: bursts requested by device, ack follows request
// R25: stop and request negation end bursts
// R26: recipient takes two or three words after pause
// R27: crc seeded 4ABA, ccitt polynomial per word
`timescale 1ns/1ps
`default_nettype none
module udbp_top
  import udbp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // host link pins
  input  wire logic        dmack_b,
  input  wire logic        stop,
  input  wire logic        hrdy_hstb,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  output logic             dq_oe,
  output logic             dmarq,
  output logic             dstb_drdy,
  output logic             ready
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  udbp_state_e         state;
  udbp_link_in_s       link_raw;
  udbp_link_in_s       link_meta;
  udbp_link_in_s       link_sync;
  udbp_link_in_s       link_prev;
  logic [2:0]          mode_num;
  logic                mode_sel;
  logic                mode_keep;
  logic                ap_wr;
  logic [31:0]         ap_addr;
  logic                dir_in;
  logic                mem_mode;
  logic                abort_crc;
  logic                busy;
  logic                done;
  logic                aborted;
  logic                mdma_req;
  logic [15:0]         rem;
  logic                crc_err;
  logic [15:0]         err_dev;
  logic [15:0]         err_host;
  logic [15:0]         crc_dev;
  logic [15:0]         tx_word;
  logic                tx_valid;
  logic                placed;
  logic [3:0]          tmr;
  logic [15:0]         rx_word;
  logic [STORE_AW:0]   rx_cnt;
  logic                ahb_go;
  logic                wr_mode;
  logic                wr_cmd;
  logic                wr_tx;
  logic                cmd_start;
  logic                srst;
  logic                rx_pop;
  logic                dmack_on;
  logic                hrdy_ok;
  logic                hstb_edge;
  logic                word_rx;
  logic                word_tx;
  logic                tx_take;
  logic                rx_room;
  logic                want_burst;
  logic                crc_bad;
  logic [31:0]         next_rdata;

  // ****************************************************************
  // link input synchronisers
  // ****************************************************************
  assign link_raw = {dmack_b, stop, hrdy_hstb, dq_in};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link_meta <= LINK_IDLE;
      link_sync <= LINK_IDLE;
      link_prev <= LINK_IDLE;
    end else begin
      link_meta <= link_raw;
      link_sync <= link_meta;
      link_prev <= link_sync;
    end
  end

  assign dmack_on  = !link_sync.dmack_b;
  assign hrdy_ok   = !link_sync.hin;                              // R4
  assign hstb_edge = link_sync.hin ^ link_prev.hin;               // R5
  // prev data was sampled a cycle before the strobe flip: widest setup
  assign word_rx   = (state == S_OUT) && hstb_edge && dmarq
                     && !link_sync.stop && (rx_cnt != STORE_FULL);
  assign word_tx   = (state == S_IN) && placed && (tmr == 4'h0)
                     && !link_sync.stop;
  assign tx_take   = (state == S_IN) && !placed && tx_valid
                     && (rem != 16'h0000) && hrdy_ok && !link_sync.stop;
  // R26
  assign rx_room   = (3'(STORE_DEPTH) - rx_cnt) > udbp_margin(mode_num);
  assign want_burst = dir_in ? tx_valid : (rx_cnt == '0);
  assign crc_bad   = link_prev.data != crc_dev;                   // R13

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  assign ahb_go    = hsel && htrans[1] && hready;
  assign wr_mode   = ap_wr && (ap_addr == ADDR_MODE);
  assign wr_cmd    = ap_wr && (ap_addr == ADDR_CMD);
  assign wr_tx     = ap_wr && (ap_addr == ADDR_TX);
  assign cmd_start = wr_cmd && hwdata[CMD_START_BIT] && !busy;
  assign srst      = wr_cmd && hwdata[CMD_SRST_BIT];
  assign rx_pop    = ahb_go && !hwrite && (haddr == ADDR_RX);

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (haddr == ADDR_MODE) begin
      next_rdata[MODE_NUM_LSB +: 3] = mode_num;
      next_rdata[MODE_SEL_BIT]      = mode_sel;
      next_rdata[MODE_KEEP_BIT]     = mode_keep;
    end else if (haddr == ADDR_CMD) begin
      next_rdata[CMD_DIR_BIT]  = dir_in;
      next_rdata[CMD_MEM_BIT]  = mem_mode;
      next_rdata[CMD_ABRT_BIT] = abort_crc;
    end else if (haddr == ADDR_STAT) begin
      next_rdata[ST_BUSY_BIT]         = busy;
      next_rdata[ST_BURST_BIT]        = (state == S_IN) || (state == S_OUT);
      next_rdata[ST_CRCE_BIT]         = crc_err;
      next_rdata[ST_DONE_BIT]         = done;
      next_rdata[ST_ABRT_BIT]         = aborted;
      next_rdata[ST_RDY_BIT]          = ready;
      next_rdata[ST_TXF_BIT]          = tx_valid;
      next_rdata[ST_MDMA_BIT]         = mdma_req;
      next_rdata[ST_RXC_LSB +: 3]     = rx_cnt;
      next_rdata[ST_REM_LSB +: 16]    = rem;
    end else if (haddr == ADDR_CRC) begin
      next_rdata = {err_host, err_dev};
    end else if (haddr == ADDR_RX) begin
      next_rdata[15:0]         = rx_word;
      next_rdata[RX_VALID_BIT] = rx_cnt != '0;
    end else if (haddr == ADDR_IDENT) begin
      next_rdata[ID_UDMA_BIT]       = 1'b1;                       // R8
      next_rdata[ID_MASK_LSB +: 5]  = UDMA_MODE_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ap_wr     <= 1'b0;
      ap_addr   <= 32'h0000_0000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ap_wr <= ahb_go && hwrite && (hsize == HSIZE_WORD);
      if (ahb_go) begin
        ap_addr <= haddr;
      end
      if (ahb_go && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // transfer mode
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_num  <= MODE_RESET;                                    // R12
      mode_sel  <= 1'b0;
      mode_keep <= 1'b0;
    end else if (srst) begin
      if (!mode_keep) begin
        mode_sel <= 1'b0;                                         // R11
      end
    end else if (wr_mode && !busy) begin
      mode_num  <= hwdata[MODE_NUM_LSB +: 3];
      // any mode up to the fastest one is taken
      mode_sel  <= hwdata[MODE_SEL_BIT]
                   && (hwdata[MODE_NUM_LSB +: 3] <= MAX_MODE);    // R10
      mode_keep <= hwdata[MODE_KEEP_BIT];
    end
  end

  // ****************************************************************
  // transmit holding word
  // ****************************************************************
  // writes while full are dropped; software polls the full bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_word  <= 16'h0000;
      tx_valid <= 1'b0;
    end else if (srst) begin
      tx_valid <= 1'b0;
    end else if (word_tx) begin
      tx_valid <= 1'b0;
    end else if (wr_tx && !tx_valid) begin
      tx_word  <= hwdata[15:0];                                   // R20
      tx_valid <= 1'b1;
    end
  end

  // ****************************************************************
  // burst crc
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      crc_dev <= CRC_SEED;
    end else if (state == S_REQ) begin
      crc_dev <= CRC_SEED;                                        // R27
    end else if (word_tx) begin
      crc_dev <= udbp_crc(crc_dev, dq_out);                       // R27
    end else if (word_rx) begin
      crc_dev <= udbp_crc(crc_dev, link_prev.data);               // R27
    end
  end

  // ****************************************************************
  // memory-mode ready pin
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ready <= 1'b1;
    end else begin
      ready <= !(mem_mode && busy);                               // R23
    end
  end

  // ****************************************************************
  // command and burst sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state     <= S_IDLE;
      dir_in    <= 1'b0;
      mem_mode  <= 1'b0;
      abort_crc <= 1'b0;
      busy      <= 1'b0;
      done      <= 1'b0;
      aborted   <= 1'b0;
      mdma_req  <= 1'b0;
      rem       <= 16'h0000;
      crc_err   <= 1'b0;
      err_dev   <= 16'h0000;
      err_host  <= 16'h0000;
      placed    <= 1'b0;
      tmr       <= 4'h0;
      dmarq     <= 1'b0;
      dq_oe     <= 1'b0;
      dq_out    <= 16'h0000;
      dstb_drdy <= 1'b1;
    end else if (srst) begin
      // card reset between bursts drops the command
      state     <= S_IDLE;
      aborted   <= busy;
      busy      <= 1'b0;
      placed    <= 1'b0;
      dmarq     <= 1'b0;
      dq_oe     <= 1'b0;
      dstb_drdy <= 1'b1;
    end else begin
      if (placed && (tmr != 4'h0)) begin
        tmr <= tmr - 4'h1;
      end
      case (state)
        S_IDLE: begin
          if (cmd_start) begin
            dir_in    <= hwdata[CMD_DIR_BIT];
            mem_mode  <= hwdata[CMD_MEM_BIT];
            abort_crc <= hwdata[CMD_ABRT_BIT];
            rem       <= hwdata[CMD_CNT_LSB +: 16];
            done      <= 1'b0;
            aborted   <= 1'b0;
            crc_err   <= 1'b0;
            // without a selected mode the multiword engine owns the data
            mdma_req  <= !mode_sel;                               // R1
            busy      <= mode_sel;
            if (mode_sel) begin
              state <= S_REQ;                                     // R1
            end
          end
        end
        S_REQ: begin
          if (want_burst) begin
            dmarq <= 1'b1;                                        // R24
          end
          if (dmarq && dmack_on) begin                            // R2
            state     <= dir_in ? S_IN : S_OUT;
            dstb_drdy <= dir_in ? 1'b1 : !rx_room;                // R4
          end
        end
        S_IN: begin
          if (link_sync.stop || !dmack_on) begin
            // host ends it: strobe back high, no word on that edge
            dmarq     <= 1'b0;                                    // R25
            dstb_drdy <= 1'b1;
            dq_oe     <= 1'b0;
            placed    <= 1'b0;
            state     <= S_TERM;
          end else if (word_tx) begin
            dstb_drdy <= !dstb_drdy;                              // R5
            placed    <= 1'b0;
            rem       <= rem - 16'h0001;
          end else if (!placed && (rem == 16'h0000)) begin
            dmarq     <= 1'b0;                                    // R25
            dstb_drdy <= 1'b1;
            dq_oe     <= 1'b0;
            state     <= S_TERM;
          end else if (tx_take) begin
            dq_out <= tx_word;                                    // R7
            dq_oe  <= 1'b1;                                       // R6
            placed <= 1'b1;
            tmr    <= udbp_half(mode_num) - 4'h1;                 // R7
          end
        end
        S_OUT: begin
          if (word_rx) begin
            rem <= rem - 16'h0001;
          end
          if (link_sync.stop || !dmack_on) begin
            dmarq     <= 1'b0;                                    // R25
            dstb_drdy <= 1'b1;
            state     <= S_TERM;
          end else if ((rem == 16'h0000)
                       || (word_rx && (rem == 16'h0001))) begin
            dmarq     <= 1'b0;                                    // R25
            dstb_drdy <= 1'b1;
            state     <= S_TERM;
          end else begin
            dstb_drdy <= !rx_room;                                // R26
          end
        end
        S_TERM: begin
          if (link_sync.dmack_b) begin
            // pins fall back to their plain meanings
            dq_oe     <= 1'b0;                                    // R3
            dstb_drdy <= 1'b1;                                    // R3
            if (crc_bad && !crc_err) begin
              crc_err  <= 1'b1;                                   // R14
              err_dev  <= crc_dev;
              err_host <= link_prev.data;
            end
            if (crc_bad && abort_crc) begin
              aborted <= 1'b1;                                    // R15
              busy    <= 1'b0;
              state   <= S_IDLE;
            end else if (rem == 16'h0000) begin
              done  <= 1'b1;                                      // R15
              busy  <= 1'b0;
              state <= S_IDLE;
            end else begin
              state <= S_REQ;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // data-out word store
  // ****************************************************************
  udbp_store u_store (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .wr_en   (word_rx),
    .wr_data (link_prev.data),
    .rd_en   (rx_pop),
    .rd_data (rx_word),
    .count   (rx_cnt)
  );

endmodule
`default_nettype wire

// >>> dv/udbp_top_assertions.sv
// udbp_top_assertions: link pin checks for udbp_top
// assumes it is bound into udbp_top on clk_sys and rst_b
`timescale 1ns/1ps
`default_nettype none
module udbp_top_assertions (
  // watched pins
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        dmack_b,
  input wire logic [15:0] dq_out,
  input wire logic        dq_oe,
  input wire logic        dmarq,
  input wire logic        dstb_drdy,
  input wire logic        ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_RST: assert property ($rose(rst_b) |-> !dmarq && !dq_oe && dstb_drdy && ready)
    else $error("pins busy after reset");
  AST_ACK: assert property ($rose(dq_oe) |-> dmarq && !$past(dmack_b, 2))
    else $error("drive before ack");
  AST_REVERT: assert property (dmack_b [*4] |-> !dq_oe)
    else $error("drive without ack");
  AST_HALF: assert property (dq_oe && $changed(dstb_drdy) |=>
    ($stable(dstb_drdy) || !dq_oe) [*2]) else $error("strobe too fast");
  AST_HOLD: assert property (dq_oe && $changed(dstb_drdy) |-> $stable(dq_out))
    else $error("data moved at strobe");
  AST_SETUP: assert property ($rose(dq_oe) |-> dstb_drdy [*3])
    else $error("first strobe early");
  AST_END: assert property ($fell(dmarq) |-> ##[0:3] (dstb_drdy && !dq_oe))
    else $error("burst end not clean");
  AST_READY: assert property ($rose(ready) |-> !dmarq)
    else $error("ready during request");
endmodule
bind udbp_top udbp_top_assertions chk (.clk_sys(clk_sys), .rst_b(rst_b), .dmack_b(dmack_b),
  .dq_out(dq_out), .dq_oe(dq_oe), .dmarq(dmarq), .dstb_drdy(dstb_drdy), .ready(ready));
`default_nettype wire

// >>> dv/udbp_host_model.sv
// udbp_host_model: behavioural host for data-in bursts
// assumes the device ends each burst by dropping dmarq
`timescale 1ns/1ps
`default_nettype none
module udbp_host_model (
  // device pins and bench control
  input  wire logic        dmarq,
  input  wire logic        dstb_drdy,
  input  wire logic [15:0] dq_out,
  input  wire logic        bad,
  // host pins
  output logic             dmack_b,
  output logic             stop,
  output logic             hin,
  output logic [15:0]      dq
);
  logic [15:0] crc;
  logic [15:0] got[$];
  function automatic logic [15:0] crc16(logic [15:0] c, logic [15:0] d);
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
    return c;
  endfunction
  initial begin
    {dmack_b, stop, hin, dq} = {3'b101, 16'h5A5A};
    forever begin
      wait (dmarq === 1'b1);
      #125 {dmack_b, hin} = 2'b00;
      crc = 16'h4ABA;
      forever begin
        @(dstb_drdy or dmarq);
        #1 if (!dmarq) break;
        got.push_back(dq_out);
        crc = crc16(crc, dq_out);
      end
      #125 {stop, dq} = {1'b1, crc ^ {15'h0, bad}};
      #125 dmack_b = 1'b1;
      // released bus shows a changed value, never the old word
      #125 {stop, hin, dq} = {2'b01, ~dq};
    end
  end
endmodule
`default_nettype wire

// >>> dv/udbp_bench.sv
// udbp_bench: self-checking bench, random data, behavioural host
// assumes the host model and the checker bind are compiled first
`timescale 1ns/1ps
`default_nettype none
module udbp_bench
  import udbp_pkg::*;
;
  logic        clk_sys = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, bad = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic        hready, dmack_b, stop, hin, dq_oe, dmarq, dstb_drdy, ready;
  logic [15:0] dq_in, dq_out, w[4];
  int          seed = 32'hE11E, failures = 0, num_checks = 0, n;
  always #5 clk_sys = ~clk_sys;
  udbp_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(), .dmack_b(dmack_b), .stop(stop),
    .hrdy_hstb(hin), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dmarq(dmarq),
    .dstb_drdy(dstb_drdy), .ready(ready));
  udbp_host_model host (.dmarq(dmarq), .dstb_drdy(dstb_drdy), .dq_out(dq_out), .bad(bad),
    .dmack_b(dmack_b), .stop(stop), .hin(hin), .dq(dq_in));
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, wr};
    do @(posedge clk_sys); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [31:0] a, m, e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, r & m);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(ADDR_IDENT, 32'h1F01, 32'h1F01, "ident");
    rd(ADDR_MODE, 32'h8, 32'h0, "mode_por");
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, ADDR_MODE, 32'h8 | m);
      rd(ADDR_MODE, 32'h8, (m < 5) ? 32'h8 : 32'h0, "mode_sel");
    end
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, ADDR_MODE, 32'h8 | (k << 4));
      bus(1'b1, ADDR_CMD, 32'h8);
      rd(ADDR_MODE, 32'h8, k ? 32'h8 : 32'h0, "soft_reset");
    end
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, ADDR_MODE, 32'h8 | ($unsigned($random(seed)) % 5));
      for (int i = 0; i < 4; i++) w[i] = 16'($random(seed));
      bus(1'b1, ADDR_TX, {16'h0, w[0]});
      rd(ADDR_STAT, 32'h40, 32'h40, "tx_full");
      bad <= k[0];
      host.got.delete();
      // only the second command runs in memory mode to move the ready pin
      bus(1'b1, ADDR_CMD, 32'h0004_0003 | (k << 2));
      r = 32'h0;
      n = 1;
      for (int i = 0; i < 300 && r[ST_DONE_BIT] !== 1'b1; i++) begin
        if (i == 2) chk("ready", {31'h0, !k[0]}, {31'h0, ready});
        bus(1'b0, ADDR_STAT, 32'h0);
        if (r[ST_TXF_BIT] === 1'b0 && n < 4) begin
          bus(1'b1, ADDR_TX, {16'h0, w[n]});
          n++;
        end
      end
      rd(ADDR_STAT, 32'hD, 32'h8 | (k << 2), "status");
      for (int i = 0; i < 4; i++) chk("word", {16'h0, w[i]}, {16'h0, host.got[i]});
    end
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(ADDR_MODE, 32'h8, 32'h0, "mode_hw_reset");
    test_done();
  end
  initial begin
    #300000;
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
